// file: pcra_pkg.sv
// Package for the performance counter readout and preload register block
package pcra_pkg;
    // Counter geometry
    localparam int EVENT_COUNTERS = 2;
    localparam int LATENCY_COUNTERS = 1;
    localparam int TOTAL_COUNTERS = EVENT_COUNTERS + LATENCY_COUNTERS;
    localparam int PTR_W = 2;
    localparam int ITEM_W = 3;
    localparam int COUNTER_WIDTH = 48;
    localparam int WORD_W = 32;
    localparam int HALF_W = 16;
    localparam int LAT_W = 32;

    // Register selectors on the debug register access port
    localparam logic [1:0] SEL_STATUS = 2'h0;
    localparam logic [1:0] SEL_READOUT = 2'h1;
    localparam logic [1:0] SEL_PRELOAD = 2'h2;
    localparam logic [1:0] SEL_COMMAND = 2'h3;

    // Command bit positions
    localparam int CMD_PTR_RESET = 0;
    localparam int CMD_SAMPLE = 1;

    // Status bit positions and reset value
    localparam int ST_FULL = 0;
    localparam int ST_OVERFLOW = 1;
    localparam logic [1:0] STATUS_RESET = 2'h0;

    // Item counts per counter for each width
    localparam logic [ITEM_W-1:0] ITEMS_EV32 = 3'h1;
    localparam logic [ITEM_W-1:0] ITEMS_LAT32 = 3'h4;
    localparam logic [ITEM_W-1:0] ITEMS_EV_WIDE = 3'h2;
    localparam logic [ITEM_W-1:0] ITEMS_LAT_WIDE = 3'h7;

    typedef logic [COUNTER_WIDTH-1:0] pcra_val_t;

    // One counter's live or sampled state
    typedef struct packed {
        pcra_val_t count;
        pcra_val_t sum;
        pcra_val_t sqSum;
        logic [LAT_W-1:0] minLat;
        logic [LAT_W-1:0] maxLat;
        logic overflow;
        logic full;
    } pcra_counter_t;

    // Debug register access from the external debug module
    typedef struct packed {
        logic valid;
        logic write;
        logic [1:0] sel;
        logic [WORD_W-1:0] wdata;
    } pcra_access_t;
endpackage

// file: pcra_readout.sv
// Performance counter status, readout and preload register block
`timescale 1ns/1ps
`default_nettype none

// Function
// - Status register is read-only, one counter per read; writes are ignored.
// - Every status read advances the status pointer to the next counter.
// - Pointer-reset command returns pointers to first counter before each pass.
// - Status bit 1 reports counter overflow past its maximum; resets to zero.
// - Status bit 0 reports latency measurement restarted while busy; resets zero.
// - Readout register returns one 32-bit sampled item per read; writes ignored.
// - Wide counters need several readout reads, in width-defined item order.
// - Width 32: event yields count; latency yields count, sum, squared sum.
// - Width 32: fourth latency item holds min in 31:16, max in 15:0.
// - Width 48 event: zero-padded upper 16 count bits, then lower 32 bits.
// - Width 48 latency: count, padded sum, padded squares, min, max; seven.
// - Width 64 event: upper 32 count bits, then lower 32 bits.
// - Width 64 latency: count, sum hi/lo, squares hi/lo, min, max.
// - Preload register is write-only; successive writes fill successive counter items.
// - Reading the preload register has no side effect; data reads as zero.
// - Preload item order and layout match the readout item sequence.
// - Access walks all event counters first, then all latency counters.
// - Sample command captures all statuses and values at once for reading.
// - Pointer-reset command rewinds status, readout and preload pointers.
module pcra_readout (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Debug register access
    input wire pcra_pkg::pcra_access_t access,
    output logic [pcra_pkg::WORD_W-1:0] readData,
    output logic readValid,
    // Live counters from the counting logic
    input wire pcra_pkg::pcra_counter_t liveCounter [pcra_pkg::TOTAL_COUNTERS],
    // Preload toward the counting logic
    output logic preloadStrobe,
    output logic [pcra_pkg::PTR_W-1:0] preloadCounter,
    output logic [pcra_pkg::ITEM_W-1:0] preloadItem,
    output logic [pcra_pkg::WORD_W-1:0] preloadData
);
    typedef struct packed {
        logic [pcra_pkg::PTR_W-1:0] statusPtr;
        logic [pcra_pkg::PTR_W-1:0] readPtr;
        logic [pcra_pkg::ITEM_W-1:0] readItem;
        logic [pcra_pkg::PTR_W-1:0] writePtr;
        logic [pcra_pkg::ITEM_W-1:0] writeItem;
        logic [pcra_pkg::WORD_W-1:0] rdata;
        logic rvalid;
        logic pStrobe;
        logic [pcra_pkg::PTR_W-1:0] pCounter;
        logic [pcra_pkg::ITEM_W-1:0] pItem;
        logic [pcra_pkg::WORD_W-1:0] pData;
    } pcra_state_t;

    pcra_state_t state;
    pcra_state_t next_state;
    // Snapshot kept outside the state struct as it is an unpacked array
    pcra_pkg::pcra_counter_t snap [pcra_pkg::TOTAL_COUNTERS];

    // Counters below EVENT_COUNTERS are event counters, walked first
    function automatic logic isLatency(input logic [pcra_pkg::PTR_W-1:0] p);
        return p >= pcra_pkg::PTR_W'(pcra_pkg::EVENT_COUNTERS);
    endfunction

    // Number of items a counter takes at the configured width
    function automatic logic [pcra_pkg::ITEM_W-1:0] itemCount(
        input logic [pcra_pkg::PTR_W-1:0] p);
        logic lat;
        lat = isLatency(p);
        if (pcra_pkg::COUNTER_WIDTH == 32) begin
            return lat ? pcra_pkg::ITEMS_LAT32 : pcra_pkg::ITEMS_EV32;
        end
        return lat ? pcra_pkg::ITEMS_LAT_WIDE : pcra_pkg::ITEMS_EV_WIDE;
    endfunction

    // Next pointer, wrapping after the last configured counter
    function automatic logic [pcra_pkg::PTR_W-1:0] nextPtr(
        input logic [pcra_pkg::PTR_W-1:0] p);
        if (p == pcra_pkg::PTR_W'(pcra_pkg::TOTAL_COUNTERS - 1)) begin
            return '0;
        end
        return p + 1'b1;
    endfunction

    // Upper part of a value, zero-padded to a word for width 48
    function automatic logic [pcra_pkg::WORD_W-1:0] upperWord(
        input pcra_pkg::pcra_val_t v);
        logic [63:0] wide;
        wide = 64'(v);
        return wide[63:32];
    endfunction

    // Item layout of one counter for the configured width
    function automatic logic [pcra_pkg::WORD_W-1:0] itemWord(
        input pcra_pkg::pcra_counter_t c,
        input logic lat,
        input logic [pcra_pkg::ITEM_W-1:0] idx);
        logic [pcra_pkg::WORD_W-1:0] w;
        w = '0;
        if (pcra_pkg::COUNTER_WIDTH == 32) begin
            unique case (idx)
                3'h0: w = c.count[31:0];
                3'h1: w = c.sum[31:0];
                3'h2: w = c.sqSum[31:0];
                default: w = {c.minLat[pcra_pkg::HALF_W-1:0],
                              c.maxLat[pcra_pkg::HALF_W-1:0]};
            endcase
        end else if (!lat) begin
            w = (idx == 3'h0) ? upperWord(c.count) : c.count[31:0];
        end else begin
            unique case (idx)
                3'h0: w = c.count[31:0];
                3'h1: w = upperWord(c.sum);
                3'h2: w = c.sum[31:0];
                3'h3: w = upperWord(c.sqSum);
                3'h4: w = c.sqSum[31:0];
                3'h5: w = c.minLat;
                default: w = c.maxLat;
            endcase
        end
        return w;
    endfunction

    logic isRead;
    logic isWrite;
    logic [pcra_pkg::WORD_W-1:0] cmdBits;

    assign isRead = access.valid && !access.write;
    assign isWrite = access.valid && access.write;
    assign cmdBits = access.wdata;

    // Access decode, pointer walk and item sequencing
    always_comb begin
        pcra_pkg::pcra_counter_t sc;
        sc = snap[state.statusPtr];
        next_state = state;
        next_state.rvalid = 1'b0;
        next_state.pStrobe = 1'b0;
        if (isRead) begin
            next_state.rvalid = 1'b1;
            unique case (access.sel)
                pcra_pkg::SEL_STATUS: begin
                    next_state.rdata = '0;
                    next_state.rdata[pcra_pkg::ST_OVERFLOW] = sc.overflow;
                    next_state.rdata[pcra_pkg::ST_FULL] = sc.full;
                    next_state.statusPtr = nextPtr(state.statusPtr);
                end
                pcra_pkg::SEL_READOUT: begin
                    next_state.rdata = itemWord(snap[state.readPtr],
                        isLatency(state.readPtr), state.readItem);
                    if (state.readItem == itemCount(state.readPtr) - 1'b1) begin
                        next_state.readItem = '0;
                        next_state.readPtr = nextPtr(state.readPtr);
                    end else begin
                        next_state.readItem = state.readItem + 1'b1;
                    end
                end
                default: begin
                    next_state.rdata = '0; // Write-only registers
                end
            endcase
        end else if (isWrite) begin
            unique case (access.sel)
                pcra_pkg::SEL_PRELOAD: begin
                    next_state.pStrobe = 1'b1;
                    next_state.pCounter = state.writePtr;
                    next_state.pItem = state.writeItem;
                    next_state.pData = access.wdata;
                    if (state.writeItem == itemCount(state.writePtr) - 1'b1)
                    begin
                        next_state.writeItem = '0;
                        next_state.writePtr = nextPtr(state.writePtr);
                    end else begin
                        next_state.writeItem = state.writeItem + 1'b1;
                    end
                end
                pcra_pkg::SEL_COMMAND: begin
                    if (cmdBits[pcra_pkg::CMD_PTR_RESET]) begin
                        next_state.statusPtr = '0;
                        next_state.readPtr = '0;
                        next_state.readItem = '0;
                        next_state.writePtr = '0;
                        next_state.writeItem = '0;
                    end
                end
                default: begin
                    // Writes to read-only registers are ignored
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Snapshot moves only on a sample command or reset, so a multi-read pass is coherent
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < pcra_pkg::TOTAL_COUNTERS; i++) begin
            if (reset) begin
                snap[i] <= '0;
            end else if (isWrite && access.sel == pcra_pkg::SEL_COMMAND
                         && cmdBits[pcra_pkg::CMD_SAMPLE]) begin
                snap[i] <= liveCounter[i];
            end
        end
    end

    // Outputs straight from flip-flops
    assign readData = state.rdata;
    assign readValid = state.rvalid;
    assign preloadStrobe = state.pStrobe;
    assign preloadCounter = state.pCounter;
    assign preloadItem = state.pItem;
    assign preloadData = state.pData;
endmodule

`default_nettype wire

// file: pcra_readout_props.sv
// Checker for the readout and preload register block
`timescale 1ns/1ps
`default_nettype none
module pcra_readout_props (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Access and answers
    input wire pcra_pkg::pcra_access_t access,
    input wire logic [31:0] readData,
    input wire logic readValid,
    input wire logic preloadStrobe,
    input wire logic [1:0] preloadCounter,
    input wire logic [2:0] preloadItem,
    input wire logic [31:0] preloadData
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // Decoded access kinds
    wire rd = access.valid && !access.write;
    wire wr = access.valid && access.write;
    wire wrPre = wr && access.sel == pcra_pkg::SEL_PRELOAD;
    wire rdPre = rd && access.sel == pcra_pkg::SEL_PRELOAD;
    wire rdSt = rd && access.sel == pcra_pkg::SEL_STATUS;
    wire rewind = wr && access.sel == pcra_pkg::SEL_COMMAND
        && access.wdata[pcra_pkg::CMD_PTR_RESET];
    // Rewind, one idle cycle, then a preload write
    sequence s_rewind; rewind ##1 !access.valid; endsequence
    sequence s_firstPre; s_rewind ##1 wrPre; endsequence
    property p_readAnswer; rd |=> readValid; endproperty
    a_readAnswer: assert property (p_readAnswer) else $error("no answer");
    property p_writeSilent; wr |=> !readValid; endproperty
    a_writeSilent: assert property (p_writeSilent) else $error("write answered");
    property p_preStrobe;
        wrPre |=> preloadStrobe && preloadData == $past(access.wdata);
    endproperty
    a_preStrobe: assert property (p_preStrobe) else $error("no preload");
    property p_preOnly; !wrPre |=> !preloadStrobe; endproperty
    a_preOnly: assert property (p_preOnly) else $error("stray preload");
    property p_preReadZero; rdPre |=> readData == 32'h0; endproperty
    a_preReadZero: assert property (p_preReadZero) else $error("data");
    property p_statusWidth; rdSt |=> readData[31:2] == 30'h0; endproperty
    a_statusWidth: assert property (p_statusWidth) else $error("status");
    property p_rewind; s_firstPre |=> preloadCounter == 2'h0 && preloadItem == 3'h0; endproperty
    a_rewind: assert property (p_rewind) else $error("not rewound");
    property p_readHold; !readValid |-> $stable(readData); endproperty
    a_readHold: assert property (p_readHold) else $error("data moved");
    property p_resetClear;
        disable iff (1'b0) reset |=> readData == 32'h0 && !readValid && !preloadStrobe;
    endproperty
    a_resetClear: assert property (p_resetClear) else $error("reset");
endmodule
bind pcra_readout pcra_readout_props pcra_readout_props_i (
    .core_clk(core_clk), .reset(reset), .access(access),
    .readData(readData), .readValid(readValid),
    .preloadStrobe(preloadStrobe), .preloadCounter(preloadCounter),
    .preloadItem(preloadItem), .preloadData(preloadData));
`default_nettype wire

// file: pcra_debug_host.sv
// Debug access model standing at the far side of the block
`timescale 1ns/1ps
`default_nettype none
module pcra_debug_host (
    // Clock
    input wire logic core_clk,
    // Access and answers
    output var pcra_pkg::pcra_access_t access,
    input wire logic [31:0] readData,
    input wire logic readValid
);
    initial access = '0;
    // One access; idle fields flip so stale values never pass as live
    task automatic xfer(input logic wr, input logic [1:0] sel,
        input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge core_clk);
        #1 access = {1'b1, wr, sel, wd};
        @(posedge core_clk);
        #1 access = {1'b0, ~wr, ~sel, ~wd};
        rd = 'x;
        // Bounded wait; an absent answer leaves unknown data behind
        for (n = 0; n < 4 && !wr; n++) begin
            if (readValid === 1'b1) begin
                rd = readData;
                break;
            end
            @(posedge core_clk);
            #1;
        end
    endtask
endmodule
`default_nettype wire

// file: tb_pcra_readout.sv
// Self-checking bench for the readout and preload register block
`timescale 1ns/1ps
`default_nettype none
module tb_pcra_readout;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    pcra_pkg::pcra_access_t access;
    logic [31:0] readData, preloadData, got;
    logic readValid, preloadStrobe;
    logic [1:0] preloadCounter;
    logic [2:0] preloadItem;
    pcra_pkg::pcra_counter_t live [pcra_pkg::TOTAL_COUNTERS];
    logic [31:0] rows [11];
    int fails = 0;
    int samples_checked = 0;
    int k, c, i;
    pcra_readout pcra_readout_i (.core_clk(core_clk), .reset(reset),
        .access(access), .readData(readData), .readValid(readValid),
        .liveCounter(live), .preloadStrobe(preloadStrobe),
        .preloadCounter(preloadCounter), .preloadItem(preloadItem),
        .preloadData(preloadData));
    pcra_debug_host pcra_debug_host_i (.core_clk(core_clk),
        .access(access), .readData(readData), .readValid(readValid));
    initial forever #4 core_clk = ~core_clk;
    // Compare tasks: plain values and the preload position
    task automatic chk(input logic [36:0] g, input logic [36:0] e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chkPre(input logic [36:0] e);
        chk({preloadCounter, preloadItem, preloadData}, e);
    endtask
    task automatic acc(input logic wr, input logic [1:0] s, input logic [31:0] w);
        pcra_debug_host_i.xfer(wr, s, w, got);
    endtask
    task automatic doReset();
        reset = 1'b1;
        repeat (3) @(posedge core_clk);
        #1 reset = 1'b0;
    endtask
    // Expected item for counter cn, item ix, at the 48-bit layout
    function automatic logic [31:0] item(input int cn, input int ix);
        pcra_pkg::pcra_counter_t v;
        v = live[cn];
        if (cn < pcra_pkg::EVENT_COUNTERS)
            return ix == 0 ? {16'h0, v.count[47:32]} : v.count[31:0];
        case (ix)
            0: return v.count[31:0];
            1: return {16'h0, v.sum[47:32]};
            2: return v.sum[31:0];
            3: return {16'h0, v.sqSum[47:32]};
            4: return v.sqSum[31:0];
            5: return v.minLat;
            default: return v.maxLat;
        endcase
    endfunction
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Watchdog against a hung run
    initial begin
        #400000 fails++;
        conclude();
    end
    // Main sequence
    initial begin
        for (k = 0; k < 3; k++) begin
            live[k] = {5{42'h2C69F3A81D5}} ^ (210'(k + 1) << (40 * k));
            {live[k].overflow, live[k].full} = 2'(k + 1);
        end
        doReset();
        acc(1'b0, pcra_pkg::SEL_STATUS, 32'h0);
        chk(got, 37'h0);
        acc(1'b1, pcra_pkg::SEL_COMMAND, 32'h3);
        k = 0;
        for (c = 0; c < 3; c++)
            for (i = 0; i < (c < 2 ? 2 : 7); i++)
                rows[k++] = item(c, i);
        acc(1'b1, pcra_pkg::SEL_READOUT, 32'hFFFF);
        for (k = 0; k < 12; k++) begin
            acc(1'b0, pcra_pkg::SEL_READOUT, 32'h0);
            chk(got, rows[k % 11]);
        end
        $display("readout items done");
        acc(1'b1, pcra_pkg::SEL_STATUS, 32'hFFFF_FFFF);
        for (k = 0; k < 4; k++) begin
            acc(1'b0, pcra_pkg::SEL_STATUS, 32'h0);
            chk(got, 37'(k % 3 + 1));
        end
        {live[0].overflow, live[0].full} = 2'h2;
        acc(1'b1, pcra_pkg::SEL_COMMAND, 32'h1);
        acc(1'b0, pcra_pkg::SEL_STATUS, 32'h0);
        chk(got, 37'h1);
        acc(1'b1, pcra_pkg::SEL_COMMAND, 32'h3);
        acc(1'b0, pcra_pkg::SEL_STATUS, 32'h0);
        chk(got, 37'h2);
        $display("status walk done");
        acc(1'b1, pcra_pkg::SEL_COMMAND, 32'h1);
        k = 0;
        for (c = 0; c < 3; c++)
            for (i = 0; i < (c < 2 ? 2 : 7); i++) begin
                acc(1'b1, pcra_pkg::SEL_PRELOAD, rows[k]);
                chkPre({c[1:0], i[2:0], rows[k++]});
                if (k == 3) begin
                    acc(1'b0, pcra_pkg::SEL_PRELOAD, 32'h0);
                    chk(got, 37'h0);
                end
            end
        $display("preload walk done");
        doReset();
        acc(1'b0, pcra_pkg::SEL_READOUT, 32'h0);
        chk(got, 37'h0);
        $display("mid-run reset done");
        conclude();
    end
endmodule
`default_nettype wire
